// ---- rcs_pkg.sv ----
// constants and types shared by the radio config and status slice
package rcs_pkg;
    // ----------------------------------------------------------------
    // register map: printed offsets are indices, byte address is 4x
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 20;
    localparam logic [15:0] IDX_THR     = 16'hdf06;
    localparam logic [15:0] IDX_RSSI    = 16'hdf07;
    localparam logic [15:0] IDX_SYNC_HI = 16'hdf08;
    localparam logic [15:0] IDX_SYNC_LO = 16'hdf09;
    localparam logic [15:0] IDX_TXH     = 16'hdf0a;
    localparam logic [15:0] IDX_TXL     = 16'hdf0b;
    localparam logic [15:0] IDX_RXH     = 16'hdf0c;
    localparam logic [ADDR_W-1:0] ADDR_THR     = {2'b00, IDX_THR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RSSI    = {2'b00, IDX_RSSI, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SYNC_HI = {2'b00, IDX_SYNC_HI, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SYNC_LO = {2'b00, IDX_SYNC_LO, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TXH     = {2'b00, IDX_TXH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TXL     = {2'b00, IDX_TXL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RXH     = {2'b00, IDX_RXH, 2'b00};
    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] THR_RST     = 8'he0;
    localparam logic [7:0] RSSI_RST    = 8'h80;
    localparam logic [7:0] SYNC_HI_RST = 8'ha7;
    localparam logic [7:0] SYNC_LO_RST = 8'h0f;
    localparam logic [7:0] TXH_RST     = 8'ha1;
    localparam logic [7:0] TXL_RST     = 8'h7f;
    localparam logic [5:0] RXH_RST     = 6'h12;
    localparam int         TURN_BIT    = 5;
    localparam logic [3:0] NIB_ONES    = 4'hf;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int SYMBOL_US     = 16;
    localparam int TURN_SHORT_US = 128;
    localparam int TURN_LONG_US  = 192;
    localparam int SYMBOL_CYC    = SYMBOL_US * CLK_MHZ;
    localparam int TURN_SHORT_CYC = TURN_SHORT_US * CLK_MHZ;
    localparam int TURN_LONG_CYC  = TURN_LONG_US * CLK_MHZ;
    localparam int AVG_DEPTH     = 8;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        GAIN_LOW  = 2'b00,
        GAIN_MED  = 2'b01,
        GAIN_HIGH = 2'b10
    } rcs_gain_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SYNC = 2'b11
    } rcs_tx_t;
endpackage : rcs_pkg

// ---- rcs_rssi_avg.sv ----
// running average of the last eight signal-strength samples
`timescale 1ns/1ps
module rcs_rssi_avg (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] sample,
    input  wire logic       sample_valid,
    output logic      [7:0] avg,
    output logic            avg_update
);
    import rcs_pkg::*;
    typedef struct packed {
        logic [AVG_DEPTH*8-1:0] win;
        logic signed [10:0]     sum;
        logic [7:0]             avg;
        logic                   upd;
    } rcs_avg_st_t;
    rcs_avg_st_t q, n;

    // window starts at the reset estimate so the first average is sane
    always_comb begin
        n     = q;
        n.upd = 1'b0;
        if (sample_valid) begin
            n.sum = q.sum + 11'($signed(sample)) - 11'($signed(q.win[AVG_DEPTH*8-1 -: 8]));
            n.win = {q.win[AVG_DEPTH*8-9:0], sample};
            n.avg = n.sum[10:3];
            n.upd = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q.win <= {AVG_DEPTH{RSSI_RST}};
            q.sum <= 11'sh400;
            q.avg <= RSSI_RST;
            q.upd <= 1'b0;
        end else begin
            q <= n;
        end
    end
    assign avg        = q.avg;
    assign avg_update = q.upd;
endmodule : rcs_rssi_avg

// ---- rcs_sync_match.sv ----
// sync pattern nibble mapping for transmit and matching for receive
`timescale 1ns/1ps
module rcs_sync_match (
    input  wire logic [15:0] pattern,
    input  wire logic [19:0] hist,
    input  wire logic [1:0]  tx_idx,
    output logic      [3:0]  tx_nibble,
    output logic             match
);
    import rcs_pkg::*;
    logic [3:0] req;
    logic [3:0] ok;
    logic [3:0] nib;
    logic [3:0] pre;

    // hist[3:0] is newest symbol; pattern nibble k sits at hist slot 3-k
    for (genvar k = 0; k < 4; k++) begin : g_nib
        assign req[k] = (pattern[4*k +: 4] != NIB_ONES);
        assign ok[k]  = !req[k] || (hist[4*(3-k) +: 4] == pattern[4*k +: 4]);
    end

    always_comb begin
        pre = hist[19:16];
        if (req[0])      pre = hist[19:16];
        else if (req[1]) pre = hist[15:12];
        else if (req[2]) pre = hist[11:8];
        else if (req[3]) pre = hist[7:4];
        else             pre = hist[3:0];
        match = (&ok) && (pre == 4'h0);
        nib   = pattern[4*tx_idx +: 4];
        tx_nibble = (nib == NIB_ONES) ? 4'h0 : nib;
    end
endmodule : rcs_sync_match

// ---- rcs_radio_cfg.sv ----
// register slice: clear-channel, sync pattern, transmit_start_delay_select, analog codes
`timescale 1ns/1ps
module rcs_radio_cfg #(
    parameter int unsigned TURN_SHORT = rcs_pkg::TURN_SHORT_CYC,
    parameter int unsigned TURN_LONG  = rcs_pkg::TURN_LONG_CYC
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite slave
    input  wire logic [rcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [rcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // receive datapath
    input  wire logic [7:0]                rssi_sample,
    input  wire logic                      rssi_sample_valid,
    input  wire logic [3:0]                rx_symbol,
    input  wire logic                      rx_symbol_valid,
    input  wire rcs_pkg::rcs_gain_t        agc_gain_sel,
    // transmit control
    input  wire logic                      transmit_on_strobe,
    output logic                           tx_start,
    output logic [3:0]                     tx_sync_symbol,
    output logic                           tx_sync_valid,
    output logic                           tx_busy,
    // status
    output logic                           clear_channel,
    output logic                           frame_sync_found,
    // analog codes
    output logic [4:0]                     amplifier_output_level,
    output logic [2:0]                     amplifier_current_trim,
    output logic                           amplifier_output_select,
    output logic [1:0]                     tx_mixer_buffer_bias,
    output logic [1:0]                     tx_mixer_varactor_select,
    output logic [1:0]                     tx_mixer_current_select,
    output logic [1:0]                     rx_mixer_buffer_bias,
    output logic [1:0]                     lna_compensation
);
    import rcs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        clear_channel_threshold;
        logic [7:0]        frame_sync_pattern_high;
        logic [7:0]        frame_sync_pattern_low;
        logic [7:0]        transmit_control_high;
        logic [7:0]        transmit_control_low;
        logic [5:0]        receive_control_high;
        logic              have_aw;
        logic [ADDR_W-1:0] waddr;
        logic              have_w;
        logic [7:0]        wdata;
        logic              wlane;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
        rcs_tx_t           tx_st;
        logic [15:0]       tx_cnt;
        logic [1:0]        nib_idx;
        logic              tx_start;
        logic [3:0]        tx_sym;
        logic              tx_valid;
        logic [19:0]       hist;
        logic              sync_found;
        logic              cca;
        logic [1:0]        lna_comp;
        logic              busy;
    } rcs_st_t;
    rcs_st_t q, n;

    logic [7:0] signal_strength_value;
    logic       rssi_upd;
    logic [3:0] tx_nibble;
    logic       sync_match;
    logic [1:0] tx_idx;
    logic       wr_en;
    logic [19:0] next_hist;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    rcs_rssi_avg u_avg (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .sample       (rssi_sample),
        .sample_valid (rssi_sample_valid),
        .avg          (signal_strength_value),
        .avg_update   (rssi_upd)
    );

    // match looks at history including the symbol arriving now
    assign next_hist = rx_symbol_valid ? {q.hist[15:0], rx_symbol} : q.hist;
    assign tx_idx    = (q.tx_st == TX_SYNC) ? q.nib_idx + 2'd1 : 2'd0;

    rcs_sync_match u_sync (
        .pattern   ({q.frame_sync_pattern_high, q.frame_sync_pattern_low}),
        .hist      (next_hist),
        .tx_idx    (tx_idx),
        .tx_nibble (tx_nibble),
        .match     (sync_match)
    );

    function automatic logic [7:0] rd_mux(input rcs_st_t s, input logic [ADDR_W-1:0] a,
                                           input logic [7:0] rssi);
        unique case (a)
            ADDR_THR:     rd_mux = s.clear_channel_threshold;
            ADDR_RSSI:    rd_mux = rssi;
            ADDR_SYNC_HI: rd_mux = s.frame_sync_pattern_high;
            ADDR_SYNC_LO: rd_mux = s.frame_sync_pattern_low;
            ADDR_TXH:     rd_mux = s.transmit_control_high;
            ADDR_TXL:     rd_mux = s.transmit_control_low;
            ADDR_RXH:     rd_mux = {2'b00, s.receive_control_high};
            default:      rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a >= ADDR_THR) && (a <= ADDR_RXH) && (a[1:0] == 2'b00);
    endfunction : mapped

    assign wr_en = q.have_aw && q.have_w && !q.bvalid;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n            = q;
        n.tx_start   = 1'b0;
        n.tx_valid   = 1'b0;
        n.sync_found = 1'b0;
        // write channel: address and data in either order
        if (s_axi_awvalid && q.awready) begin
            n.have_aw = 1'b1;
            n.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            n.have_w = 1'b1;
            n.wdata  = s_axi_wdata[7:0];
            n.wlane  = s_axi_wstrb[0];
        end
        if (wr_en) begin
            n.have_aw = 1'b0;
            n.have_w  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = mapped(q.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (q.wlane) begin
                unique case (q.waddr)
                    ADDR_THR:     n.clear_channel_threshold = q.wdata;
                    ADDR_SYNC_HI: n.frame_sync_pattern_high = q.wdata;
                    ADDR_SYNC_LO: n.frame_sync_pattern_low  = q.wdata;
                    ADDR_TXH:     n.transmit_control_high   = q.wdata;
                    ADDR_TXL:     n.transmit_control_low    = q.wdata;
                    ADDR_RXH:     n.receive_control_high    = q.wdata[5:0];
                    default:      n.bresp = n.bresp; // estimate is read-only
                endcase
            end
        end else if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        n.awready = !n.have_aw && !n.bvalid;
        n.wready  = !n.have_w && !n.bvalid;
        // read channel: one word in flight
        if (s_axi_arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_mux(q, s_axi_araddr, signal_strength_value);
            n.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.arready = !n.rvalid;

        // compare runs every cycle, so clear_channel follows each estimate update one cycle later
        n.cca = $signed(signal_strength_value) < $signed(q.clear_channel_threshold);

        // lna compensation picked by the agc gain step
        unique case (agc_gain_sel)
            GAIN_HIGH: n.lna_comp = q.receive_control_high[3:2];
            GAIN_MED:  n.lna_comp = q.receive_control_high[1:0];
            default:   n.lna_comp = 2'b00;
        endcase

        // receive sync search
        n.hist = next_hist;
        if (rx_symbol_valid && sync_match) begin
            n.sync_found = 1'b1;
        end

        // transmit turnaround then sync pattern symbols
        unique case (q.tx_st)
            TX_IDLE: begin
                if (transmit_on_strobe) begin
                    n.tx_st  = TX_WAIT;
                    n.tx_cnt = q.transmit_control_high[TURN_BIT] ? 16'(TURN_LONG - 1)
                                                                 : 16'(TURN_SHORT - 1);
                end
            end
            TX_WAIT: begin
                if (q.tx_cnt == 16'h0000) begin
                    n.tx_st    = TX_SYNC;
                    n.tx_start = 1'b1;
                    n.nib_idx  = 2'd0;
                    n.tx_sym   = tx_nibble;
                    n.tx_valid = 1'b1;
                    n.tx_cnt   = 16'(SYMBOL_CYC - 1);
                end else begin
                    n.tx_cnt = q.tx_cnt - 16'h0001;
                end
            end
            TX_SYNC: begin
                if (q.tx_cnt != 16'h0000) begin
                    n.tx_cnt = q.tx_cnt - 16'h0001;
                end else if (q.nib_idx == 2'd3) begin
                    n.tx_st = TX_IDLE;
                end else begin
                    n.nib_idx  = tx_idx; // low nibble first
                    n.tx_sym   = tx_nibble;
                    n.tx_valid = 1'b1;
                    n.tx_cnt   = 16'(SYMBOL_CYC - 1);
                end
            end
        endcase
        // busy is registered so the pin comes straight from a flop
        n.busy = (n.tx_st != TX_IDLE);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q                         <= '0;
            q.clear_channel_threshold <= THR_RST;
            q.frame_sync_pattern_high <= SYNC_HI_RST;
            q.frame_sync_pattern_low  <= SYNC_LO_RST;
            q.transmit_control_high   <= TXH_RST;
            q.transmit_control_low    <= TXL_RST;
            q.receive_control_high    <= RXH_RST;
            q.hist                    <= 20'hfffff;
            q.tx_st                   <= TX_IDLE;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = {24'h000000, q.rdata};
    assign s_axi_rresp   = q.rresp;
    assign tx_start      = q.tx_start;
    assign tx_sync_symbol = q.tx_sym;
    assign tx_sync_valid = q.tx_valid;
    assign tx_busy       = q.busy;
    assign clear_channel = q.cca;
    assign frame_sync_found = q.sync_found;
    // static codes straight from the holding registers; lna_compensation comes from the registered gain pick
    assign amplifier_output_level   = q.transmit_control_low[4:0];
    assign amplifier_current_trim   = q.transmit_control_low[7:5];
    assign amplifier_output_select  = q.transmit_control_high[0];
    assign tx_mixer_buffer_bias     = q.transmit_control_high[7:6];
    assign tx_mixer_varactor_select = q.transmit_control_high[4:3];
    assign tx_mixer_current_select  = q.transmit_control_high[2:1];
    assign rx_mixer_buffer_bias     = q.receive_control_high[5:4];
    assign lna_compensation         = q.lna_comp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_cca_compare: assert property (
        aresetn |=> clear_channel == ($signed($past(signal_strength_value)) < $signed($past(q.clear_channel_threshold))))
        else $error("clear channel does not follow compare");
    chk_cca_lag: assert property (
        rssi_upd |=> clear_channel == ($signed($past(signal_strength_value)) < $signed($past(q.clear_channel_threshold))))
        else $error("clear channel lags estimate");
    chk_tx_no_ones: assert property (
        tx_sync_valid |-> tx_sync_symbol != NIB_ONES)
        else $error("all-ones symbol transmitted");
    chk_tx_turn_wait: assert property (
        (q.tx_st == TX_IDLE && transmit_on_strobe) |=> q.tx_cnt ==
            ($past(q.transmit_control_high[TURN_BIT]) ? 16'(TURN_LONG - 1) : 16'(TURN_SHORT - 1)))
        else $error("wrong turnaround count loaded");
    chk_start_after_wait: assert property (
        $rose(tx_start) |-> $past(q.tx_st) == TX_WAIT && $past(q.tx_cnt) == 16'h0000)
        else $error("transmit started early");
    chk_rsv_read_zero: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_RXH) |=> s_axi_rdata[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    chk_static_codes: assert property (
        !wr_en |=> $stable(q.transmit_control_high) && $stable(q.transmit_control_low)
                   && $stable(q.receive_control_high))
        else $error("analog code changed without write");
    chk_med_comp: assert property (
        (aresetn && agc_gain_sel == GAIN_MED) |=> lna_compensation == $past(q.receive_control_high[1:0]))
        else $error("medium gain compensation not applied");
    chk_lna_high: assert property (
        (aresetn && agc_gain_sel == GAIN_HIGH) |=> lna_compensation == $past(q.receive_control_high[3:2]))
        else $error("high gain compensation not applied");
    chk_busy_start: assert property (
        (transmit_on_strobe && !tx_busy) |=> tx_busy)
        else $error("strobe did not start turnaround");
    chk_sync_idle: assert property (
        !rx_symbol_valid |=> !frame_sync_found)
        else $error("sync found without a symbol");
    chk_rdata_hold: assert property (
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_sync_cause: assert property (
        frame_sync_found |-> $past(rx_symbol_valid && sync_match))
        else $error("sync found without match");
    chk_bresp_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped");

    cov_tx_frame: cover property (tx_start ##1 tx_busy [*3]);
    cov_sync_found: cover property (frame_sync_found);
    cov_cca_high: cover property ($rose(clear_channel));
    cov_write_read: cover property (s_axi_bvalid ##[1:20] s_axi_rvalid);
endmodule : rcs_radio_cfg

// ---- rcs_radio_cfg_tb_top.sv ----
// self-checking bench for the radio config slice
`timescale 1ns/1ps
module rcs_radio_cfg_tb_top;
import rcs_pkg::*;
localparam int TB_SHORT = 8;
localparam int TB_LONG  = 12;
// reset sync pattern as sent: all-ones nibble replaced by zero
localparam logic [15:0] TX_SYMS = 16'ha700;
logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, sv = 0, strb = 0, bq = 0, rq = 0, rxv = 0;
logic [3:0] rxs = '0;
logic [19:0] awa = '0, ara = '0;
logic [7:0] wd = '0, ss = '0;
rcs_gain_t g = GAIN_MED;
logic awr, wrd, bv, arr, rv, cc, tst, sel, tsv, busy, fsf;
logic [1:0] br, rrs, txb, vs, cs, rxb, lna;
logic [31:0] rdat;
logic [3:0] tss;
logic [4:0] lvl;
logic [2:0] trim;
int num_errors = 0, total_checks = 0, i;
always #5 aclk = ~aclk;
// short turnaround counts keep the run brief
rcs_radio_cfg #(.TURN_SHORT(TB_SHORT), .TURN_LONG(TB_LONG)) u_rcs_radio_cfg (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata({24'h0, wd}), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs),
    .s_axi_rvalid(rv), .s_axi_rready(rq), .rssi_sample(ss), .rssi_sample_valid(sv), .rx_symbol(rxs),
    .rx_symbol_valid(rxv), .agc_gain_sel(g), .transmit_on_strobe(strb), .tx_start(tst), .tx_sync_symbol(tss),
    .tx_sync_valid(tsv), .tx_busy(busy), .clear_channel(cc), .frame_sync_found(fsf), .amplifier_output_level(lvl),
    .amplifier_current_trim(trim), .amplifier_output_select(sel), .tx_mixer_buffer_bias(txb),
    .tx_mixer_varactor_select(vs), .tx_mixer_current_select(cs), .rx_mixer_buffer_bias(rxb), .lna_compensation(lna));
task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask : report_and_stop
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", nm, e, s);
    end
endtask : chk
// handshakes are judged on the values each rising edge samples;
// bready and rready rise a cycle late so the slave must hold its answer
task automatic wr_reg(input logic [19:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    bit hb;
    logic [1:0] r;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 50 && !hb; n++) begin
        @(posedge aclk);
        if (awv && awr) awv <= 1'b0;
        if (wv && wrd) wv <= 1'b0;
        if (bv && bq) begin
            hb = 1'b1;
            r = br;
            bq <= 1'b0;
        end else if (bv) begin
            bq <= 1'b1;
        end
    end
    if (!hb) begin num_errors++; report_and_stop(); end
    chk("bresp", {30'h0, e}, {30'h0, r});
endtask : wr_reg
task automatic rd_reg(input logic [19:0] a, input logic [7:0] e);
    int n;
    bit hv;
    logic [31:0] d;
    logic [1:0] r;
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 50 && !hv; n++) begin
        @(posedge aclk);
        if (arv && arr) arv <= 1'b0;
        if (rv && rq) begin
            hv = 1'b1;
            d = rdat;
            r = rrs;
            rq <= 1'b0;
        end else if (rv) begin
            rq <= 1'b1;
        end
    end
    if (!hv) begin num_errors++; report_and_stop(); end
    chk("rdata", {24'h0, e}, d);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
endtask : rd_reg
// four received symbols back to back, oldest first
task automatic rx_seq(input logic [15:0] syms, input logic e);
    int k;
    for (k = 3; k >= 0; k--) begin
        rxs <= syms[4*k +: 4];
        rxv <= 1'b1;
        @(posedge aclk);
    end
    rxv <= 1'b0;
    @(negedge aclk);
    chk("sync found", {31'h0, e}, {31'h0, fsf});
    @(posedge aclk);
endtask : rx_seq
// one transmit-on strobe: turnaround, four sync symbols, back to idle
task automatic tx_run(input int turn);
    int k;
    int n;
    @(posedge aclk);
    strb <= 1'b1;
    @(posedge aclk);
    strb <= 1'b0;
    for (i = 0; i < 40; i++) begin
        @(negedge aclk);
        if (tst) break;
    end
    chk("turnaround", turn, i);
    chk("busy", 1, busy);
    chk("first sym", {1'b1, TX_SYMS[3:0]}, {tsv, tss});
    for (k = 1; k < 4; k++) begin
        @(negedge aclk);
        for (n = 0; n < 2000 && !tsv; n++) @(negedge aclk);
        if (!tsv) begin num_errors++; report_and_stop(); end
        chk("sym gap", SYMBOL_CYC - 1, n);
        chk("sync sym", {28'h0, TX_SYMS[4*k +: 4]}, {28'h0, tss});
    end
    for (n = 0; n < 2000 && busy; n++) @(negedge aclk);
    chk("idle wait", SYMBOL_CYC, n);
    @(posedge aclk);
endtask : tx_run
initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(ADDR_THR, 8'he0);
    rd_reg(ADDR_RSSI, 8'h80);
    rd_reg(ADDR_SYNC_HI, 8'ha7);
    rd_reg(ADDR_SYNC_LO, 8'h0f);
    rd_reg(ADDR_TXH, 8'ha1);
    rd_reg(ADDR_TXL, 8'h7f);
    rd_reg(ADDR_RXH, 8'h12);
    chk("analog", {5'h1f, 3'h3, 1'b1, 2'h2, 2'h0, 2'h0, 2'h1}, {lvl, trim, sel, txb, vs, cs, rxb});
    chk("lna med", 2'h2, lna);
    g <= GAIN_HIGH;
    wr_reg(ADDR_RSSI, 8'h55, RESP_OKAY);
    rd_reg(ADDR_RSSI, 8'h80);
    chk("lna high", 2'h0, lna);
    wr_reg(ADDR_RXH, 8'hff, RESP_OKAY);
    chk("lna high", 2'h3, lna);
    g <= GAIN_LOW;
    rd_reg(ADDR_RXH, 8'h3f);
    chk("rx codes", {2'h3, 2'h0}, {rxb, lna});
    wr_reg(20'h37c34, 8'h00, RESP_SLVERR);
    wr_reg(ADDR_TXL, 8'h45, RESP_OKAY);
    chk("amp", {5'h05, 3'h2}, {lvl, trim});
    wr_reg(ADDR_THR, 8'h20, RESP_OKAY);
    for (i = 0; i < 8; i++) begin
        ss <= 8'hf0; sv <= 1'b1;
        @(posedge aclk);
        sv <= 1'b0;
        @(posedge aclk);
    end
    rd_reg(ADDR_RSSI, 8'hf0);
    chk("clear lo", 1, cc);
    wr_reg(ADDR_THR, 8'hf0, RESP_OKAY);
    chk("clear eq", 0, cc);
    rx_seq(16'h507a, 1'b0);
    rx_seq(16'h007a, 1'b1);
    tx_run(TB_LONG);
    wr_reg(ADDR_TXH, 8'h9b, RESP_OKAY);
    chk("tx codes", {2'h2, 2'h3, 2'h1, 1'b1}, {txb, vs, cs, sel});
    tx_run(TB_SHORT);
    report_and_stop();
end
endmodule : rcs_radio_cfg_tb_top
